// ### wdt_chk.sv
// Checker for the watchdog top: read-back, key faults, reset pulse, freeze.
// Sees only top ports; it keeps its own copy of control and irq mask.
`timescale 1ns/1ps
module wdt_chk #(
    parameter int CNT_W = 24
) (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       osc_ref_clock,
    input wire logic       bdm_active,
    input wire logic       wait_mode,
    input wire logic       pseudo_stop_mode,
    input wire logic       wd_reset_req,
    input wire logic       rti_freeze,
    input wire logic       irq
);
    logic [7:0] ctrl_q;
    logic       locked;
    logic [3:0] mask_q;
    logic       key_wr;
    logic       bad_key;
    assign key_wr  = wr && addr == wdt_pkg::ADDR_KEY;
    assign bad_key = key_wr && wdata != wdt_pkg::KEY_FIRST && wdata != wdt_pkg::KEY_SECOND;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_q <= wdt_pkg::CTRL_RESET;
            locked <= 1'b0;
            mask_q <= 4'h0;
        end else begin
            if (wr && addr == wdt_pkg::ADDR_CTRL && !locked) begin
                ctrl_q <= wdata & wdt_pkg::CTRL_RW_MASK;
                locked <= 1'b1;
            end
            if (wr && addr == wdt_pkg::ADDR_IRQ_MASK) begin
                mask_q <= wdata[3:0];
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_pulse; wd_reset_req |=> !wd_reset_req; endproperty
    a_pulse: assert property (p_pulse)
        else $error("reset request wider than one cycle");
    property p_bad; bad_key && ctrl_q[2:0] != 3'h0 |=> wd_reset_req; endproperty
    a_bad: assert property (p_bad)
        else $error("bad key did not request reset");
    property p_irq; bad_key && ctrl_q[2:0] != 3'h0 && mask_q[1] |-> ##2 irq; endproperty
    a_irq: assert property (p_irq)
        else $error("bad key event did not raise irq");
    property p_off; ctrl_q[2:0] == 3'h0 |=> !wd_reset_req; endproperty
    a_off: assert property (p_off)
        else $error("reset request while watchdog off");
    property p_keyok;
        key_wr && !bad_key && !ctrl_q[7] |=> !wd_reset_req;
    endproperty
    a_keyok: assert property (p_keyok)
        else $error("key byte in normal mode caused reset");
    property p_keyrd; rd && addr == wdt_pkg::ADDR_KEY |=> rdata == 8'h00; endproperty
    a_keyrd: assert property (p_keyrd)
        else $error("restart key register read nonzero");
    property p_ctlrd; rd && addr == wdt_pkg::ADDR_CTRL |=> rdata == ctrl_q; endproperty
    a_ctlrd: assert property (p_ctlrd)
        else $error("control read-back wrong");
    property p_frz; 1'b1 |=> rti_freeze == $past(bdm_active && ctrl_q[6]); endproperty
    a_frz: assert property (p_frz)
        else $error("timer freeze does not follow debug halt");
    c_bad: cover property (bad_key && ctrl_q[2:0] != 3'h0);
    c_restart: cover property (key_wr && wdata == wdt_pkg::KEY_SECOND);
    c_frz: cover property ($rose(rti_freeze));
endmodule : wdt_chk
bind wdt_top wdt_chk #(.CNT_W(CNT_W)) u_chk (.mclk(mclk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_ref_clock(osc_ref_clock),
    .bdm_active(bdm_active), .wait_mode(wait_mode), .pseudo_stop_mode(pseudo_stop_mode),
    .wd_reset_req(wd_reset_req), .rti_freeze(rti_freeze), .irq(irq));

// ### wdt_counter.sv
// Reference-clock period counter of the watchdog.
// Assumes osc_ref_clock is a slow level synchronous to mclk; each rising
// edge seen on it is one reference period.
`timescale 1ns/1ps
module wdt_counter #(
    parameter int CNT_W = 24
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             osc_ref_clock,
    input  wire logic             clear,
    input  wire logic             hold,
    output logic [CNT_W-1:0]      count,
    output logic                  advance
);

    logic             ref_prev;
    logic             next_ref_prev;
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_ref_prev = osc_ref_clock;
        // Clear stays out of advance: the time-out feeds back into clear
        advance       = osc_ref_clock & ~ref_prev & ~hold;
        next_count    = count;
        if (clear) begin
            next_count = '0;
        end else if (advance) begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ref_prev <= 1'b0;
            count    <= '0;
        end else begin
            ref_prev <= next_ref_prev;
            count    <= next_count;
        end
    end

endmodule : wdt_counter

// ### wdt_pkg.sv
// Shared constants for the windowed watchdog: register map, field layout,
// reset values, key bytes and rate exponents.
// Assumes a byte-wide register port with eight address bits.
package wdt_pkg;

    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 8;
    localparam int          RATE_W            = 3;
    localparam int          EXP_W             = 5;
    localparam int          EV_W              = 4;

    // Register offsets
    localparam logic [7:0]  ADDR_CTRL         = 8'h3c;
    localparam logic [7:0]  ADDR_KEY          = 8'h3f;
    localparam logic [7:0]  ADDR_AUX          = 8'h30;
    localparam logic [7:0]  ADDR_IRQ_STAT     = 8'h31;
    localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h32;
    localparam logic [7:0]  ADDR_STATE        = 8'h33;

    // Reset values and read masks
    localparam logic [7:0]  CTRL_RESET        = 8'h43;
    localparam logic [7:0]  CTRL_RW_MASK      = 8'hc7;
    localparam logic [7:0]  KEY_READ_VALUE    = 8'h00;
    localparam logic [1:0]  AUX_RESET         = 2'h0;
    localparam logic [3:0]  IRQ_STAT_RESET    = 4'h0;
    localparam logic [3:0]  IRQ_MASK_RESET    = 4'h0;
    localparam logic [7:0]  READ_ZERO         = 8'h00;

    // Key bytes
    localparam logic [7:0]  KEY_FIRST         = 8'h55;
    localparam logic [7:0]  KEY_SECOND        = 8'haa;

    // Control field positions
    localparam int          CTRL_WINDOW_BIT   = 7;
    localparam int          CTRL_DBG_HALT_BIT = 6;
    localparam int          CTRL_RATE_LSB     = 0;

    // Auxiliary control field positions
    localparam int          AUX_WAIT_HALT_BIT = 0;
    localparam int          AUX_PSTOP_RUN_BIT = 1;

    // Event bits, shared by status and mask
    localparam int          EV_TIMEOUT        = 0;
    localparam int          EV_BAD_KEY        = 1;
    localparam int          EV_EARLY          = 2;
    localparam int          EV_RESTART        = 3;

    // State register bit positions
    localparam int          ST_ENABLED        = 0;
    localparam int          ST_IN_WINDOW      = 1;
    localparam int          ST_ARMED          = 2;
    localparam int          ST_CTRL_LOCKED    = 3;

    // Divide exponents of the reference clock per rate code
    localparam logic [4:0]  RATE_EXP_1        = 5'd14;
    localparam logic [4:0]  RATE_EXP_2        = 5'd16;
    localparam logic [4:0]  RATE_EXP_3        = 5'd18;
    localparam logic [4:0]  RATE_EXP_4        = 5'd20;
    localparam logic [4:0]  RATE_EXP_5        = 5'd22;
    localparam logic [4:0]  RATE_EXP_6        = 5'd23;
    localparam logic [4:0]  RATE_EXP_7        = 5'd24;
    localparam logic [4:0]  RATE_EXP_OFF      = 5'd0;

    // The window is the last quarter: two top bits of the period both set
    localparam logic [4:0]  WINDOW_SHIFT      = 5'd2;

    function automatic logic [EXP_W-1:0] rate_exp(input logic [RATE_W-1:0] rate);
        logic [EXP_W-1:0] e;
        e = RATE_EXP_OFF;
        case (rate)
            3'h1:    e = RATE_EXP_1;
            3'h2:    e = RATE_EXP_2;
            3'h3:    e = RATE_EXP_3;
            3'h4:    e = RATE_EXP_4;
            3'h5:    e = RATE_EXP_5;
            3'h6:    e = RATE_EXP_6;
            3'h7:    e = RATE_EXP_7;
            default: e = RATE_EXP_OFF;
        endcase
        return e;
    endfunction : rate_exp

endpackage : wdt_pkg

// ### wdt_top.sv
// Windowed watchdog: register port, key sequence checker, window and
// time-out detection, low-power and debug halting, event interrupt.
// Assumes a single-cycle strobe master and an external reset generator
// that turns wd_reset_req into a system reset.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module wdt_top #(
    parameter int CNT_W = 24
) (
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    input  wire logic [wdt_pkg::ADDR_W-1:0] addr,
    input  wire logic [wdt_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [wdt_pkg::DATA_W-1:0] rdata,
    input  wire logic                       osc_ref_clock,
    input  wire logic                       bdm_active,
    input  wire logic                       wait_mode,
    input  wire logic                       pseudo_stop_mode,
    output logic                            wd_reset_req,
    output logic                            rti_freeze,
    output logic                            irq
);

    logic [7:0]                     ctrl;
    logic [7:0]                     next_ctrl;
    logic                           ctrl_locked;
    logic                           next_ctrl_locked;
    logic [1:0]                     aux;
    logic [1:0]                     next_aux;
    logic [wdt_pkg::EV_W-1:0]       irq_stat;
    logic [wdt_pkg::EV_W-1:0]       next_irq_stat;
    logic [wdt_pkg::EV_W-1:0]       irq_mask;
    logic [wdt_pkg::EV_W-1:0]       next_irq_mask;
    logic                           armed;
    logic                           next_armed;
    logic [wdt_pkg::DATA_W-1:0]     next_rdata;
    logic                           next_wd_reset_req;
    logic                           next_rti_freeze;
    logic                           next_irq;

    logic [wdt_pkg::RATE_W-1:0]     rate;
    logic [wdt_pkg::EXP_W-1:0]      exp_sel;
    logic                           enabled;
    logic                           window_mode;
    logic                           debug_halt;
    logic                           wait_halt;
    logic                           pstop_run;
    logic [CNT_W-1:0]               count;
    logic                           advance;
    logic                           cnt_clear;
    logic                           cnt_hold;
    logic                           in_window;
    logic                           timeout;
    logic                           key_wr;
    logic                           ctrl_wr;
    logic                           bad_key;
    logic                           early;
    logic                           restart;
    logic                           fire;
    logic [wdt_pkg::EV_W-1:0]       events;

    function automatic logic [CNT_W-1:0] last_count(input logic [wdt_pkg::EXP_W-1:0] e);
        logic [CNT_W:0] full;
        full = ({{CNT_W{1'b0}}, 1'b1} << e) - {{CNT_W{1'b0}}, 1'b1};
        return full[CNT_W-1:0];
    endfunction : last_count

    function automatic logic window_open(input logic [CNT_W-1:0]          c,
                                         input logic [wdt_pkg::EXP_W-1:0] e);
        logic [CNT_W-1:0] top;
        top = c >> (e - wdt_pkg::WINDOW_SHIFT);
        return top == CNT_W'(3);
    endfunction : window_open

    assign rate        = ctrl[wdt_pkg::CTRL_RATE_LSB +: wdt_pkg::RATE_W];
    assign exp_sel     = wdt_pkg::rate_exp(rate);
    assign enabled     = (rate != 3'h0);
    assign window_mode = ctrl[wdt_pkg::CTRL_WINDOW_BIT];
    assign debug_halt  = ctrl[wdt_pkg::CTRL_DBG_HALT_BIT];
    assign wait_halt   = aux[wdt_pkg::AUX_WAIT_HALT_BIT];
    assign pstop_run   = aux[wdt_pkg::AUX_PSTOP_RUN_BIT];

    assign key_wr  = wr && (addr == wdt_pkg::ADDR_KEY) && enabled;
    assign ctrl_wr = wr && (addr == wdt_pkg::ADDR_CTRL) && !ctrl_locked;

    // Key sequence; writes elsewhere on the bus, except an accepted control write, do not disturb the armed flag
    always_comb begin
        bad_key    = 1'b0;
        early      = 1'b0;
        restart    = 1'b0;
        next_armed = armed;
        if (key_wr) begin
            if (window_mode && !in_window) begin
                early = 1'b1;
            end else if (wdata == wdt_pkg::KEY_FIRST) begin
                next_armed = 1'b1;
            end else if (wdata == wdt_pkg::KEY_SECOND) begin
                restart    = armed;
                next_armed = 1'b0;
            end else begin
                bad_key = 1'b1;
            end
        end
        if (fire || cnt_clear && !restart) begin
            next_armed = 1'b0;
        end
    end

    assign in_window = enabled && window_open(count, exp_sel);
    assign timeout   = enabled && advance && !restart && !ctrl_wr
                     && (count == last_count(exp_sel));
    assign fire      = timeout | bad_key | early;

    // Wait-mode halt reinitialises; pseudo-stop and debug only freeze
    assign cnt_clear = restart | ctrl_wr | fire | (wait_mode & wait_halt);
    assign cnt_hold  = ~enabled
                     | (bdm_active & debug_halt)
                     | (pseudo_stop_mode & ~pstop_run);

    wdt_counter #(
        .CNT_W         (CNT_W)
    ) u_counter (
        .mclk          (mclk),
        .rstn          (rstn),
        .osc_ref_clock (osc_ref_clock),
        .clear         (cnt_clear),
        .hold          (cnt_hold),
        .count         (count),
        .advance       (advance)
    );

    always_comb begin
        events                        = '0;
        events[wdt_pkg::EV_TIMEOUT]   = timeout;
        events[wdt_pkg::EV_BAD_KEY]   = bad_key;
        events[wdt_pkg::EV_EARLY]     = early;
        events[wdt_pkg::EV_RESTART]   = restart;
    end

    // Register writes; a late rewrite of the control is silently dropped
    always_comb begin
        next_ctrl        = ctrl;
        next_ctrl_locked = ctrl_locked;
        next_aux         = aux;
        next_irq_mask    = irq_mask;
        next_irq_stat    = irq_stat;
        if (ctrl_wr) begin
            next_ctrl        = wdata & wdt_pkg::CTRL_RW_MASK;
            next_ctrl_locked = 1'b1;
        end
        if (wr && addr == wdt_pkg::ADDR_AUX) begin
            next_aux = wdata[1:0];
        end
        if (wr && addr == wdt_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = wdata[wdt_pkg::EV_W-1:0];
        end
        if (wr && addr == wdt_pkg::ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~wdata[wdt_pkg::EV_W-1:0];
        end
        // A new event beats a simultaneous clear
        next_irq_stat = next_irq_stat | events;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    // Read decode; data stand only in the cycle after the strobe
    always_comb begin
        next_rdata = wdt_pkg::READ_ZERO;
        if (!rd) begin
            next_rdata = wdt_pkg::READ_ZERO;
        end else if (addr == wdt_pkg::ADDR_CTRL) begin
            next_rdata = ctrl & wdt_pkg::CTRL_RW_MASK;
        end else if (addr == wdt_pkg::ADDR_KEY) begin
            next_rdata = wdt_pkg::KEY_READ_VALUE;
        end else if (addr == wdt_pkg::ADDR_AUX) begin
            next_rdata = {6'h00, aux};
        end else if (addr == wdt_pkg::ADDR_IRQ_STAT) begin
            next_rdata = {4'h0, irq_stat};
        end else if (addr == wdt_pkg::ADDR_IRQ_MASK) begin
            next_rdata = {4'h0, irq_mask};
        end else if (addr == wdt_pkg::ADDR_STATE) begin
            next_rdata                          = wdt_pkg::READ_ZERO;
            next_rdata[wdt_pkg::ST_ENABLED]     = enabled;
            next_rdata[wdt_pkg::ST_IN_WINDOW]   = in_window;
            next_rdata[wdt_pkg::ST_ARMED]       = armed;
            next_rdata[wdt_pkg::ST_CTRL_LOCKED] = ctrl_locked;
        end else begin
            next_rdata = wdt_pkg::READ_ZERO;
        end
    end

    // The periodic timer sits elsewhere; it only needs the freeze level
    assign next_rti_freeze   = bdm_active & debug_halt;
    assign next_wd_reset_req = fire;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl         <= wdt_pkg::CTRL_RESET;
            ctrl_locked  <= 1'b0;
            aux          <= wdt_pkg::AUX_RESET;
            irq_stat     <= wdt_pkg::IRQ_STAT_RESET;
            irq_mask     <= wdt_pkg::IRQ_MASK_RESET;
            armed        <= 1'b0;
            rdata        <= wdt_pkg::READ_ZERO;
            wd_reset_req <= 1'b0;
            rti_freeze   <= 1'b0;
            irq          <= 1'b0;
        end else begin
            ctrl         <= next_ctrl;
            ctrl_locked  <= next_ctrl_locked;
            aux          <= next_aux;
            irq_stat     <= next_irq_stat;
            irq_mask     <= next_irq_mask;
            armed        <= next_armed;
            rdata        <= next_rdata;
            wd_reset_req <= next_wd_reset_req;
            rti_freeze   <= next_rti_freeze;
            irq          <= next_irq;
        end
    end

endmodule : wdt_top

// ### windowed_watchdog_timer_bench.sv
// Self-checking bench for the watchdog; a reference-edge model predicts time-outs.
// Assumes the bound checker and a 20 MHz bus clock.
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
    localparam int NPER = 1 << 14;
    localparam int WIN  = 3 << 12;
    logic       mclk, rstn, wr, rd, osc_ref_clock, bdm_active, wait_mode, pseudo_stop_mode;
    logic [7:0] addr, wdata, rdata, v;
    logic       wd_reset_req, rti_freeze, irq, osc_prev, m_dbg, m_wh, m_arm;
    int         n_mismatch, num_checks, seed, m_cnt, osc_ph, i;
    wdt_top #(.CNT_W(24)) uut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .osc_ref_clock(osc_ref_clock),
        .bdm_active(bdm_active), .wait_mode(wait_mode), .pseudo_stop_mode(pseudo_stop_mode),
        .wd_reset_req(wd_reset_req), .rti_freeze(rti_freeze), .irq(irq));
    always #25 mclk = ~mclk;
    // Reference high one cycle in three: must stay slower than half mclk
    always @(posedge mclk) begin
        osc_ph <= (osc_ph == 2) ? 0 : osc_ph + 1;
        osc_ref_clock <= (osc_ph == 2);
    end
    always @(posedge mclk) begin
        if (wait_mode && m_wh) m_cnt = 0;
        else if (osc_ref_clock && !osc_prev && !(bdm_active && m_dbg) && !pseudo_stop_mode)
            m_cnt++;
        osc_prev = osc_ref_clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask : rd_reg
    task automatic key(input logic [7:0] d, input logic exp);
        wr_reg(wdt_pkg::ADDR_KEY, d);
        chk({7'h0, wd_reset_req}, {7'h0, exp}, "reset after key write");
        if (exp) begin
            m_cnt = 0;
            m_arm = 1'b0;
        end else if (d == wdt_pkg::KEY_FIRST) begin
            m_arm = 1'b1;
        end else if (d == wdt_pkg::KEY_SECOND && m_arm) begin
            m_cnt = 0;
            m_arm = 1'b0;
        end
    endtask : key
    task automatic irq_is(input logic exp);
        @(posedge mclk);
        #1;
        chk({7'h0, irq}, {7'h0, exp}, "irq level");
    endtask : irq_is
    task automatic do_reset;
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        m_dbg = 1'b1;
        m_wh = 1'b0;
        m_arm = 1'b0;
    endtask : do_reset
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial begin
        // Longest path: three quarters of one period plus one full period
        repeat (95000) @(posedge mclk);
        n_mismatch++;
        $display("mismatch at %0t: run did not finish", $time);
        close_out;
    end
    initial begin
        {mclk, wr, rd, rstn, osc_ref_clock, bdm_active, wait_mode, pseudo_stop_mode} = '0;
        {addr, wdata, osc_ph, m_cnt, osc_prev} = '0;
        seed = 32'h8b19;
        do_reset;
        rd_reg(wdt_pkg::ADDR_CTRL, 8'h43, "control reset value");
        rd_reg(wdt_pkg::ADDR_KEY, 8'h00, "key reads zero");
        rd_reg(8'h3e, 8'h00, "unmapped read");
        wr_reg(wdt_pkg::ADDR_IRQ_MASK, 8'h0f);
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            if (v == 8'h55 || v == 8'haa) v = 8'h5a;
            key(v, 1'b1);
            irq_is(1'b1);
            wr_reg(wdt_pkg::ADDR_IRQ_STAT, 8'h0f);
            irq_is(1'b0);
        end
        wr_reg(wdt_pkg::ADDR_IRQ_MASK, 8'h0d);
        key(8'h00, 1'b1);
        irq_is(1'b0);
        key(8'h55, 1'b0);
        key(8'h55, 1'b0);
        wr_reg(wdt_pkg::ADDR_AUX, 8'h00);
        key(8'haa, 1'b0);
        key(8'haa, 1'b0);
        rd_reg(wdt_pkg::ADDR_IRQ_STAT, 8'h0a, "bad key and restart events");
        $display("test normal mode done");
        do_reset;
        wr_reg(wdt_pkg::ADDR_CTRL, 8'h00);
        wr_reg(wdt_pkg::ADDR_CTRL, 8'h81);
        rd_reg(wdt_pkg::ADDR_CTRL, 8'h00, "control write once");
        for (i = 0; i < 3; i++) key(8'($random(seed)), 1'b0);
        $display("test disabled done");
        do_reset;
        wr_reg(wdt_pkg::ADDR_AUX, 8'h01);
        m_wh = 1'b1;
        wr_reg(wdt_pkg::ADDR_CTRL, 8'hc1);
        m_cnt = 0;
        rd_reg(wdt_pkg::ADDR_CTRL, 8'hc1, "window control");
        repeat (100) @(posedge mclk);
        key(8'h55, 1'b1);
        while (m_cnt < WIN + 20) @(posedge mclk);
        key(8'h55, 1'b0);
        key(8'h55, 1'b0);
        key(8'haa, 1'b0);
        key(8'h55, 1'b1);
        repeat (300) @(posedge mclk);
        wait_mode <= 1'b1;
        repeat (50) @(posedge mclk);
        wait_mode <= 1'b0;
        // Frozen spans come before the time-out, so its count proves the freeze
        @(posedge mclk);
        bdm_active <= 1'b1;
        repeat (600) @(posedge mclk);
        #1;
        chk({7'h0, rti_freeze}, 8'h01, "timer freeze");
        @(posedge mclk);
        bdm_active <= 1'b0;
        pseudo_stop_mode <= 1'b1;
        repeat (600) @(posedge mclk);
        pseudo_stop_mode <= 1'b0;
        #1;
        chk({7'h0, rti_freeze}, 8'h00, "timer freeze released");
        i = 0;
        while (wd_reset_req !== 1'b1 && i < 60000) begin
            @(posedge mclk);
            #1;
            i++;
        end
        chk({7'h0, m_cnt >= NPER - 2 && m_cnt <= NPER + 1}, 8'h01, "time-out");
        $display("test window and time-out done");
        close_out;
    end
endmodule : windowed_watchdog_timer_bench
